// ==== common/uepib_pkg.sv ====
/*
  Package for the serial port event bank: register offsets, field positions,
  reset values and event numbering shared by the design and its checks.
  Assumes a 12-bit byte address on the register port and 32-bit data.
*/
package uepib_pkg;

  // ----------------------------------------------------------------------
  // event numbering
  // ----------------------------------------------------------------------
  localparam int EVT_COUNT = 11;
  localparam int EV_CTS = 0;
  localparam int EV_NOT_CLEAR_TO_SEND = 1;
  localparam int EV_RX_BYTE_READY = 2;
  localparam int EV_RX_BUFFER_FULL = 3;
  localparam int EV_TX_BYTE_SENT = 4;
  localparam int EV_TX_BUFFER_DONE = 5;
  localparam int EV_ERROR = 6;
  localparam int EV_RECEIVE_TIMEOUT = 7;
  localparam int EV_RECEIVER_BEGUN = 8;
  localparam int EV_TRANSMITTER_BEGUN = 9;
  localparam int EV_TRANSMITTER_HALTED = 10;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] FLAG_OFS [EVT_COUNT] = '{12'h100, 12'h104, 12'h108, 12'h110,
    12'h11C, 12'h120, 12'h124, 12'h144, 12'h14C, 12'h150, 12'h158};
  localparam logic [11:0] PUB_OFS [EVT_COUNT] = '{12'h180, 12'h184, 12'h188, 12'h190,
    12'h19C, 12'h1A0, 12'h1A4, 12'h1C4, 12'h1CC, 12'h1D0, 12'h1D8};
  localparam logic [11:0] SHORTCUTS_OFS = 12'h200;
  localparam logic [11:0] IRQ_ENABLE_OFS = 12'h300;
  localparam logic [11:0] LOG_STAT_OFS = 12'h310;

  // ----------------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------------
  localparam int IRQ_ENABLE_POS [EVT_COUNT] = '{0, 1, 2, 4, 7, 8, 9, 17, 19, 20, 22};
  localparam int SC_FULL_RESTARTS_POS = 5;
  localparam int SC_FULL_HALTS_POS = 6;
  localparam int PUB_EN_POS = 31;
  localparam int CHAN_INDEX_W = 8;
  localparam int CHAN_COUNT = 256;
  localparam int LOG_DEPTH = 4;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // mask of the writable interrupt enable bits, built from their positions
  function automatic logic [31:0] uepib_irq_enable_mask();
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < EVT_COUNT; i++) begin
      m[IRQ_ENABLE_POS[i]] = 1'b1;
    end
    return m;
  endfunction : uepib_irq_enable_mask

endpackage : uepib_pkg

// ==== logic/uepib_top.sv ====
/*
  Event flags, publish channels, shortcuts and interrupt enables of the
  dma serial port, plus a small event log FIFO.
  Assumes event inputs are one-cycle pulses synchronous to CLK_SYS and the
  register master follows the plain strobe port protocol.
*/
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// event log FIFO
// ------------------------------------------------------------------------
module uepib_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // full and empty come straight from the fill count
  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // pointers wrap at depth, so depth need not be a power of two
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : uepib_fifo

// ------------------------------------------------------------------------
// event bank top
// ------------------------------------------------------------------------
module uepib_top #(
  parameter int CHANNELS = uepib_pkg::CHAN_COUNT,
  parameter int LOG_WORDS = uepib_pkg::LOG_DEPTH
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [11:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic CTS_N,
  input wire logic EVT_RX_BYTE_READY,
  input wire logic EVT_RX_BUFFER_FULL,
  input wire logic EVT_TX_BYTE_SENT,
  input wire logic EVT_TX_BUFFER_DONE,
  input wire logic EVT_ERROR,
  input wire logic EVT_RECEIVE_TIMEOUT,
  input wire logic EVT_RECEIVER_BEGUN,
  input wire logic EVT_TRANSMITTER_BEGUN,
  input wire logic EVT_TRANSMITTER_HALTED,
  output logic TASK_RECEIVE_BEGIN,
  output logic TASK_RECEIVE_HALT,
  output logic IRQ,
  output logic [CHANNELS-1:0] CHAN_PULSE,
  output logic LOG_SPACE,
  output logic LOG_VALID,
  input wire logic LOG_READY,
  output logic [uepib_pkg::EVT_COUNT-1:0] LOG_DATA
);
  localparam int N = uepib_pkg::EVT_COUNT;
  localparam int CW = uepib_pkg::CHAN_INDEX_W;
  localparam logic [31:0] IRQ_ENABLE_MASK = uepib_pkg::uepib_irq_enable_mask();
  // only the two shortcut bits are stored; the rest read zero
  localparam logic [31:0] SHORTCUT_MASK = (32'h1 << uepib_pkg::SC_FULL_RESTARTS_POS)
    | (32'h1 << uepib_pkg::SC_FULL_HALTS_POS);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic cts_n_prev;
  logic [N-1:0] evt;
  logic [N-1:0] flag;
  logic [N-1:0] pub_en;
  logic [CW-1:0] pub_ch [N];
  logic [31:0] shortcuts;
  logic [31:0] irq_enable;
  logic log_overflow;
  logic [N-1:0] flag_hit;
  logic [N-1:0] pub_hit;
  logic [N-1:0] irq_src;
  logic [CHANNELS-1:0] next_chan;
  logic [31:0] rd_word;
  logic log_in_ready;

  // ----------------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------------
  // flow input is taken as synchronous; its idle level is high
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cts_n_prev <= 1'b1;
    end else begin
      cts_n_prev <= CTS_N;
    end
  end

  // edge detection on the flow input, pulses straight from the engine
  assign evt[uepib_pkg::EV_CTS] = cts_n_prev && !CTS_N;
  assign evt[uepib_pkg::EV_NOT_CLEAR_TO_SEND] = !cts_n_prev && CTS_N;
  assign evt[uepib_pkg::EV_RX_BYTE_READY] = EVT_RX_BYTE_READY;
  assign evt[uepib_pkg::EV_RX_BUFFER_FULL] = EVT_RX_BUFFER_FULL;
  assign evt[uepib_pkg::EV_TX_BYTE_SENT] = EVT_TX_BYTE_SENT;
  assign evt[uepib_pkg::EV_TX_BUFFER_DONE] = EVT_TX_BUFFER_DONE;
  assign evt[uepib_pkg::EV_ERROR] = EVT_ERROR;
  assign evt[uepib_pkg::EV_RECEIVE_TIMEOUT] = EVT_RECEIVE_TIMEOUT;
  assign evt[uepib_pkg::EV_RECEIVER_BEGUN] = EVT_RECEIVER_BEGUN;
  assign evt[uepib_pkg::EV_TRANSMITTER_BEGUN] = EVT_TRANSMITTER_BEGUN;
  assign evt[uepib_pkg::EV_TRANSMITTER_HALTED] = EVT_TRANSMITTER_HALTED;

  // ----------------------------------------------------------------------
  // per-event flag and publish registers
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_evt
    wire wr_flag = WR && (ADDR == uepib_pkg::FLAG_OFS[i]);
    wire wr_pub = WR && (ADDR == uepib_pkg::PUB_OFS[i]);
    assign flag_hit[i] = (ADDR == uepib_pkg::FLAG_OFS[i]);
    assign pub_hit[i] = (ADDR == uepib_pkg::PUB_OFS[i]);
    assign irq_src[i] = flag[i] && irq_enable[uepib_pkg::IRQ_ENABLE_POS[i]];

    // the event wins over a software clear landing in the same cycle
    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        flag[i] <= 1'b0;
      end else if (evt[i]) begin
        flag[i] <= 1'b1;
      end else if (wr_flag) begin
        flag[i] <= WDATA[0];
      end
    end

    // channel index in the low bits, enable at the top bit
    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        pub_en[i] <= uepib_pkg::REG_RESET[uepib_pkg::PUB_EN_POS];
        pub_ch[i] <= uepib_pkg::REG_RESET[CW-1:0];
      end else if (wr_pub) begin
        pub_en[i] <= WDATA[uepib_pkg::PUB_EN_POS];
        pub_ch[i] <= WDATA[CW-1:0];
      end
    end

    chk_flag_sets: assert property (@(posedge CLK_SYS) disable iff (RST)
      evt[i] |=> flag[i])
      else $error("event did not set its flag");
    chk_flag_holds: assert property (@(posedge CLK_SYS) disable iff (RST)
      flag[i] && !wr_flag |=> flag[i])
      else $error("flag dropped without a software write");
    chk_pub_pulse: assert property (@(posedge CLK_SYS) disable iff (RST)
      evt[i] && pub_en[i] |=> CHAN_PULSE[$past(pub_ch[i])] ##1 !CHAN_PULSE[$past(pub_ch[i], 2)]
        || $past(evt, 1) != '0)
      else $error("publish pulse missing or too long");
  end

  // ----------------------------------------------------------------------
  // publish channel pulses
  // ----------------------------------------------------------------------
  // independent of flags and interrupt enables; several events may share a channel
  always_comb begin
    next_chan = '0;
    for (int i = 0; i < N; i++) begin
      if (evt[i] && pub_en[i]) begin
        next_chan[pub_ch[i]] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      CHAN_PULSE <= '0;
    end else begin
      CHAN_PULSE <= next_chan;
    end
  end

  chk_pub_silent: assert property (@(posedge CLK_SYS) disable iff (RST)
    (pub_en == '0) |=> (CHAN_PULSE == '0))
    else $error("pulse on a channel with publishing disabled");

  // ----------------------------------------------------------------------
  // shortcuts, enables and log status
  // ----------------------------------------------------------------------
  wire wr_shortcuts = WR && (ADDR == uepib_pkg::SHORTCUTS_OFS);
  wire wr_irq_enable = WR && (ADDR == uepib_pkg::IRQ_ENABLE_OFS);
  wire wr_log_stat = WR && (ADDR == uepib_pkg::LOG_STAT_OFS);
  wire short_restart = shortcuts[uepib_pkg::SC_FULL_RESTARTS_POS];
  wire short_halt = shortcuts[uepib_pkg::SC_FULL_HALTS_POS];
  wire log_drop = (evt != '0) && !log_in_ready;

  // only the two shortcut bits and the event enable bits are kept
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      shortcuts <= uepib_pkg::REG_RESET;
      irq_enable <= uepib_pkg::REG_RESET;
    end else begin
      if (wr_shortcuts) begin
        shortcuts <= WDATA & SHORTCUT_MASK;
      end
      if (wr_irq_enable) begin
        irq_enable <= WDATA & IRQ_ENABLE_MASK;
      end
    end
  end

  // overflow stays set until written 0; a new drop wins over the clear
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      log_overflow <= 1'b0;
    end else if (log_drop) begin
      log_overflow <= 1'b1;
    end else if (wr_log_stat) begin
      log_overflow <= WDATA[0];
    end
  end

  // tasks fire one cycle after the buffer fills; both may fire together
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      TASK_RECEIVE_BEGIN <= 1'b0;
      TASK_RECEIVE_HALT <= 1'b0;
    end else begin
      TASK_RECEIVE_BEGIN <= evt[uepib_pkg::EV_RX_BUFFER_FULL] && short_restart;
      TASK_RECEIVE_HALT <= evt[uepib_pkg::EV_RX_BUFFER_FULL] && short_halt;
    end
  end

  chk_short_begin: assert property (@(posedge CLK_SYS) disable iff (RST)
    TASK_RECEIVE_BEGIN == $past(EVT_RX_BUFFER_FULL && short_restart))
    else $error("receive begin task does not follow the shortcut");
  chk_short_halt: assert property (@(posedge CLK_SYS) disable iff (RST)
    !short_halt ##1 !short_halt |-> !TASK_RECEIVE_HALT)
    else $error("receive halt task fired with shortcut off");
  chk_short_halt_on: assert property (@(posedge CLK_SYS) disable iff (RST)
    EVT_RX_BUFFER_FULL && short_halt |=> TASK_RECEIVE_HALT)
    else $error("receive halt task missing with shortcut on");
  chk_cts_edge: assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(CTS_N) && !CTS_N |=> flag[uepib_pkg::EV_CTS])
    else $error("clear to send edge not flagged");

  // ----------------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------------
  // registered so the request is glitch free; it lags the flag by a cycle
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (irq_src != '0);
    end
  end

  chk_irq_level: assert property (@(posedge CLK_SYS) disable iff (RST)
    (irq_src != '0) [*2] |-> IRQ)
    else $error("request low while an enabled flag is set");
  chk_irq_masked: assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(irq_src) == '0 |-> !IRQ)
    else $error("request high with no enabled flag");

  // ----------------------------------------------------------------------
  // event log
  // ----------------------------------------------------------------------
  // each cycle with any event pushes a snapshot; a full log drops it
  uepib_fifo #(
    .WIDTH(N),
    .DEPTH(LOG_WORDS)
  ) u_log (
    .clk(CLK_SYS),
    .rst(RST),
    .in_valid(evt != '0),
    .in_ready(log_in_ready),
    .in_data(evt),
    .out_valid(LOG_VALID),
    .out_ready(LOG_READY),
    .out_data(LOG_DATA)
  );

  assign LOG_SPACE = log_in_ready;

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  // unmapped addresses read zero; reserved bits read zero
  always_comb begin
    rd_word = '0;
    for (int i = 0; i < N; i++) begin
      if (flag_hit[i]) begin
        rd_word = {31'h0, flag[i]};
      end
      if (pub_hit[i]) begin
        rd_word = {pub_en[i], {(31 - CW){1'b0}}, pub_ch[i]};
      end
    end
    if (ADDR == uepib_pkg::SHORTCUTS_OFS) begin
      rd_word = shortcuts;
    end
    if (ADDR == uepib_pkg::IRQ_ENABLE_OFS) begin
      rd_word = irq_enable;
    end
    if (ADDR == uepib_pkg::LOG_STAT_OFS) begin
      rd_word = {30'h0, log_in_ready, log_overflow};
    end
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RDATA <= '0;
    end else begin
      RDATA <= RD ? rd_word : '0;
    end
  end

  chk_read_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
    !RD |=> RDATA == '0)
    else $error("read data present without a read strobe");
  chk_reset_zero: assert property (@(posedge CLK_SYS)
    $past(RST) |-> shortcuts == '0 && pub_en == '0 && irq_enable == '0)
    else $error("configuration not cleared by reset");

endmodule : uepib_top

// ==== dv/uepib_remote.sv ====
/*
  Behavioural far side of the event bank: the remote flow control line and
  the consumer of the event log.
  Assumes the bench changes cts_low and stall right after a rising edge.
*/
`timescale 1ns/1ps

module uepib_remote (
  input wire logic cts_low,
  input wire logic stall,
  output logic cts_n,
  output logic log_ready
);
  // ----------------------------------------------------------------------
  // line and consumer
  // ----------------------------------------------------------------------
  // flow line is idle high; the remote pulls it low to allow sending
  assign cts_n = ~cts_low;
  // a stalled consumer leaves the head word in place so order can be seen
  assign log_ready = ~stall;
endmodule : uepib_remote

// ==== dv/test_uepib_top.sv ====
/*
  Self-checking bench for the event bank: registers, flags, publish pulses,
  shortcuts, interrupt request and the event log.
  Assumes the remote model in uepib_remote and the shared package.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end

module test_uepib_top;
  logic clk_sys, rst, wr, rd, cts_low, stall, task_begin, task_halt, irq;
  logic log_space, log_valid, log_ready, cts_n;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, rv, imask;
  logic [10:0] ev, log_data;
  logic [255:0] chan;
  logic [7:0] ch;
  int errors, check_count;

  uepib_top i_uepib_top (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CTS_N(cts_n), .EVT_RX_BYTE_READY(ev[2]),
    .EVT_RX_BUFFER_FULL(ev[3]), .EVT_TX_BYTE_SENT(ev[4]), .EVT_TX_BUFFER_DONE(ev[5]),
    .EVT_ERROR(ev[6]), .EVT_RECEIVE_TIMEOUT(ev[7]), .EVT_RECEIVER_BEGUN(ev[8]),
    .EVT_TRANSMITTER_BEGUN(ev[9]), .EVT_TRANSMITTER_HALTED(ev[10]),
    .TASK_RECEIVE_BEGIN(task_begin), .TASK_RECEIVE_HALT(task_halt), .IRQ(irq),
    .CHAN_PULSE(chan), .LOG_SPACE(log_space), .LOG_VALID(log_valid), .LOG_READY(log_ready),
    .LOG_DATA(log_data));
  uepib_remote i_uepib_remote (.cts_low(cts_low), .stall(stall), .cts_n(cts_n),
    .log_ready(log_ready));

  // ----------------------------------------------------------------------
  // register port and event drivers
  // ----------------------------------------------------------------------
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk_sys) wr <= 1'b0;
  endtask : reg_wr
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys) begin addr <= a; rd <= 1'b1; end
    @(posedge clk_sys) rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd
  // one-cycle event pulse, returns just after the edge that took it
  task automatic fire(input int i);
    @(posedge clk_sys) ev <= 11'h001 << i;
    @(posedge clk_sys) ev <= '0;
    #1;
  endtask : fire
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < uepib_pkg::EVT_COUNT; i++) begin
      reg_rd(uepib_pkg::PUB_OFS[i], rv);
      `CHK("publish reset", uepib_pkg::REG_RESET, rv)
      reg_rd(uepib_pkg::FLAG_OFS[i], rv);
      `CHK("flag reset", uepib_pkg::REG_RESET, rv)
    end
    reg_rd(uepib_pkg::SHORTCUTS_OFS, rv);
    `CHK("shortcut reset", uepib_pkg::REG_RESET, rv)
    reg_rd(uepib_pkg::IRQ_ENABLE_OFS, rv);
    `CHK("enable reset", uepib_pkg::REG_RESET, rv)
    reg_rd(12'h7F0, rv);
    `CHK("unmapped read", 32'h0000_0000, rv)
  endtask : t_reset

  // publish config, one-cycle channel pulse, flag set and software clear
  task automatic t_events();
    for (int i = 2; i < uepib_pkg::EVT_COUNT; i++) begin
      ch = (i == 2) ? 8'hFF : 8'(i * 23);
      reg_wr(uepib_pkg::PUB_OFS[i], 32'hFFFF_FF00 | 32'(ch));
      reg_rd(uepib_pkg::PUB_OFS[i], rv);
      `CHK("publish field", 32'h8000_0000 | 32'(ch), rv)
      fire(i);
      `CHK("channel pulse", 256'h1 << ch, chan)
      tick();
      `CHK("pulse width", 256'h0, chan)
      reg_rd(uepib_pkg::FLAG_OFS[i], rv);
      `CHK("flag set", 32'h0000_0001, rv)
      reg_wr(uepib_pkg::FLAG_OFS[i], 32'h0000_0000);
      reg_rd(uepib_pkg::FLAG_OFS[i], rv);
      `CHK("flag clear", 32'h0000_0000, rv)
      reg_wr(uepib_pkg::PUB_OFS[i], 32'(ch));
      fire(i);
      `CHK("publish off", 256'h0, chan)
      reg_wr(uepib_pkg::FLAG_OFS[i], 32'h0000_0000);
    end
    // an event landing on the same edge as a software clear keeps its flag
    fork
      reg_wr(uepib_pkg::FLAG_OFS[6], 32'h0000_0000);
      fire(6);
    join
    reg_rd(uepib_pkg::FLAG_OFS[6], rv);
    `CHK("set beats clear", 32'h0000_0001, rv)
    reg_wr(uepib_pkg::FLAG_OFS[6], 32'h0000_0000);
  endtask : t_events

  // only the event whose enable bit is set may raise the request
  task automatic t_irq();
    imask = '0;
    for (int i = 0; i < uepib_pkg::EVT_COUNT; i++) imask[uepib_pkg::IRQ_ENABLE_POS[i]] = 1'b1;
    reg_wr(uepib_pkg::IRQ_ENABLE_OFS, 32'hFFFF_FFFF);
    reg_rd(uepib_pkg::IRQ_ENABLE_OFS, rv);
    `CHK("enable mask", imask, rv)
    for (int i = 2; i < uepib_pkg::EVT_COUNT; i++) begin
      reg_wr(uepib_pkg::IRQ_ENABLE_OFS, 32'h1 << uepib_pkg::IRQ_ENABLE_POS[i]);
      fire((i == 10) ? 2 : i + 1);
      tick();
      `CHK("masked request", 1'b0, irq)
      reg_wr(uepib_pkg::FLAG_OFS[(i == 10) ? 2 : i + 1], 32'h0000_0000);
      fire(i);
      tick();
      tick();
      `CHK("request held", 1'b1, irq)
      reg_wr(uepib_pkg::FLAG_OFS[i], 32'h0000_0000);
      tick();
      `CHK("request cleared", 1'b0, irq)
    end
    reg_wr(uepib_pkg::IRQ_ENABLE_OFS, 32'h0000_0000);
  endtask : t_irq

  // buffer full starts or halts the receiver only when its bit is set
  task automatic t_event_task_shortcuts();
    logic [31:0] sv [4];
    logic [31:0] want;
    sv = '{32'h0000_0020, 32'h0000_0040, 32'h0000_0060, 32'h0000_0000};
    want = (32'h1 << uepib_pkg::SC_FULL_RESTARTS_POS) | (32'h1 << uepib_pkg::SC_FULL_HALTS_POS);
    // reserved shortcut bits must read back as zero
    reg_wr(uepib_pkg::SHORTCUTS_OFS, 32'hFFFF_FFFF);
    reg_rd(uepib_pkg::SHORTCUTS_OFS, rv);
    `CHK("shortcut bits", want, rv)
    for (int k = 0; k < 4; k++) begin
      reg_wr(uepib_pkg::SHORTCUTS_OFS, sv[k]);
      fire(uepib_pkg::EV_RX_BUFFER_FULL);
      `CHK("receive begin", sv[k][5], task_begin)
      `CHK("receive halt", sv[k][6], task_halt)
      tick();
      `CHK("task width", 2'b00, {task_begin, task_halt})
    end
    reg_wr(uepib_pkg::FLAG_OFS[3], 32'h0000_0000);
  endtask : t_event_task_shortcuts

  // falling flow line gives clear to send, rising gives not clear to send
  task automatic t_cts();
    reg_wr(uepib_pkg::IRQ_ENABLE_OFS, 32'h1 << uepib_pkg::IRQ_ENABLE_POS[1]);
    @(posedge clk_sys) cts_low <= 1'b1;
    repeat (3) tick();
    reg_rd(uepib_pkg::FLAG_OFS[0], rv);
    `CHK("clear to send", 32'h0000_0001, rv)
    reg_rd(uepib_pkg::FLAG_OFS[1], rv);
    `CHK("no early not clear", 32'h0000_0000, rv)
    `CHK("cts not enabled", 1'b0, irq)
    @(posedge clk_sys) cts_low <= 1'b0;
    repeat (3) tick();
    reg_rd(uepib_pkg::FLAG_OFS[1], rv);
    `CHK("not clear to send", 32'h0000_0001, rv)
    `CHK("not clear request", 1'b1, irq)
    reg_wr(uepib_pkg::IRQ_ENABLE_OFS, 32'h0000_0000);
  endtask : t_cts

  // fill the log past its depth with the consumer stalled, then drain in order
  task automatic t_log();
    tick();
    `CHK("log empty", 1'b0, log_valid)
    @(posedge clk_sys) stall <= 1'b1;
    for (int i = 2; i < 7; i++) fire(i);
    `CHK("log full", 1'b0, log_space)
    reg_rd(uepib_pkg::LOG_STAT_OFS, rv);
    `CHK("log overflow", 1'b1, rv[0])
    for (int i = 2; i < 6; i++) begin
      `CHK("log order", 11'h001 << i, log_data)
      @(posedge clk_sys) stall <= 1'b0;
      @(posedge clk_sys) stall <= 1'b1;
      #1;
    end
    `CHK("log drained", 2'b01, {log_valid, log_space})
    @(posedge clk_sys) stall <= 1'b0;
    // writing 0 clears the sticky overflow; space shows in bit 1
    reg_wr(uepib_pkg::LOG_STAT_OFS, 32'h0000_0000);
    reg_rd(uepib_pkg::LOG_STAT_OFS, rv);
    `CHK("log status clear", 32'h0000_0002, rv)
  endtask : t_log

  // ----------------------------------------------------------------------
  // clock, reset, sequence and verdict
  // ----------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // the whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_sim();
  end

  initial begin
    errors = 0;
    check_count = 0;
    rst = 1'b1;
    {wr, rd, cts_low, stall} = '0;
    addr = '0;
    wdata = '0;
    ev = '0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_events();
    t_irq();
    t_event_task_shortcuts();
    t_cts();
    t_log();
    end_sim();
  end
endmodule : test_uepib_top
